// [src/tx_dc_offset_calibration_sequencer.sv]
// Transmit I/Q dc offset calibration sequencer with its host registers
//
// Notes on behaviour
// - Calibrate standalone or ahead of transmission
// - Keep corrections, apply later, host reads
// - Command loop transmitter via pass-through select
// - Sample references on converter channel two
// - Programmable correction gain and iteration count
// - Measure errors in low gain first
// - Add characterised offset on low-to-high switch
// - Setup initialises port, converter, selects I reference
// - Read references, then select I error
// - Low gain: I then Q, iterate after settling
// - Raise gain and offset before high stages
// - High gain: Q then I, iterate after settling
// - Tidy-up restores transmitter pre-calibration state
// - Completion sets transmit-done status flag
// - Stage settling times are programmable
// - Stages optional; high stages force gain raise
// - Transmit calibration runs before transmission starts
`timescale 1ns/1ps
`default_nettype none
module tx_dc_offset_calibration_sequencer (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             adc_start,
	output logic      [1:0]  adc_channel,
	input  wire logic        adc_done,
	input  wire logic [9:0]  adc_data,
	output logic             spi_sclk,
	output logic             spi_mosi,
	output logic             passthru_select_1_n,
	output logic      [9:0]  i_dc_out,
	output logic      [9:0]  q_dc_out,
	output logic             tx_enable,
	output logic             cal_busy
);
	// ==========================================================
	// State
	typedef struct packed {
		txcal_pkg::stage_t stage;
		txcal_pkg::phase_t phase;
		logic [15:0]       lohi_i;
		logic [15:0]       lohi_q;
		logic [15:0]       cfg;
		logic [15:0]       timing;
		logic [9:0]        ref_i;
		logic [9:0]        ref_q;
		logic [9:0]        corr_i;
		logic [9:0]        corr_q;
		logic [3:0]        iter;
		logic              loop_settle;
		logic [7:0]        settle_cnt;
		logic [4:0]        tick_cnt;
		logic              tx_after;
		logic              tx_en;
		logic              tx_done;
		logic [15:0]       rdata;
		logic [15:0]       ser_word;
		logic              ser_go;
		logic              conv_go;
		logic              conv_clear;
	} seq_t;
	seq_t st_reg, st_next;

	logic              ser_busy;
	logic              ser_done;
	logic [9:0]        conv_result;
	logic              conv_valid;
	logic              start_req;
	logic              done_set;
	logic              rd_clear;
	logic [1:0]        wr_mode;
	txcal_pkg::stage_t nxt_stage;

	assign wr_mode = reg_wdata[txcal_pkg::MODE_LSB +: 2];

	// ==========================================================
	// Helpers
	function automatic logic [9:0] saturate(input logic signed [15:0] sum);
		if (sum > txcal_pkg::CORR_MAX) begin
			return txcal_pkg::CORR_MAX[9:0];
		end else if (sum < txcal_pkg::CORR_MIN) begin
			return txcal_pkg::CORR_MIN[9:0];
		end
		return sum[9:0];
	endfunction : saturate

	// Damped step: corr - gain * (meas - ref) / 2^GAIN_FRAC
	function automatic logic [9:0] correct(input logic [9:0] corr, input logic [9:0] meas,
		input logic [9:0] ref_lvl, input logic [3:0] gain);
		logic signed [15:0] err;
		logic signed [15:0] step;
		err  = $signed({6'h00, meas}) - $signed({6'h00, ref_lvl});
		step = (err * $signed({12'h000, gain})) >>> txcal_pkg::GAIN_FRAC;
		return saturate($signed({{6{corr[9]}}, corr}) - step);
	endfunction : correct

	function automatic logic [9:0] add_offset(input logic [9:0] corr, input logic [15:0] off);
		return saturate($signed({{6{corr[9]}}, corr}) + $signed({{6{off[9]}}, off[9:0]}));
	endfunction : add_offset

	function automatic txcal_pkg::stage_t next_stage(input txcal_pkg::stage_t s, input logic [15:0] cfg,
		input logic [3:0] iter);
		logic last;
		logic raise_en;
		last     = (iter + 4'h1) >= cfg[txcal_pkg::CFG_ITER_LSB +: 4];
		raise_en = cfg[txcal_pkg::CFG_RAISE_BIT] | cfg[txcal_pkg::CFG_HIGH_BIT];
		case (s)
			txcal_pkg::STG_SETUP: return txcal_pkg::STG_IREF;
			txcal_pkg::STG_IREF:  return txcal_pkg::STG_QREF;
			txcal_pkg::STG_QREF: begin
				if (cfg[txcal_pkg::CFG_LOW_BIT]) begin
					return txcal_pkg::STG_ILO;
				end
				return raise_en ? txcal_pkg::STG_RAISE : txcal_pkg::STG_TIDY;
			end
			txcal_pkg::STG_ILO: return txcal_pkg::STG_QLO;
			txcal_pkg::STG_QLO: begin
				if (!last) begin
					return txcal_pkg::STG_ILO;
				end
				return raise_en ? txcal_pkg::STG_RAISE : txcal_pkg::STG_TIDY;
			end
			txcal_pkg::STG_RAISE: return cfg[txcal_pkg::CFG_HIGH_BIT] ? txcal_pkg::STG_QHI : txcal_pkg::STG_TIDY;
			txcal_pkg::STG_QHI:   return txcal_pkg::STG_IHI;
			txcal_pkg::STG_IHI:   return last ? txcal_pkg::STG_TIDY : txcal_pkg::STG_QHI;
			default:              return txcal_pkg::STG_TIDY;
		endcase
	endfunction : next_stage

	// Measurement selection sent ahead of each stage after setup; tidy-up gets the restore word
	function automatic logic [15:0] select_word(input txcal_pkg::stage_t s);
		case (s)
			txcal_pkg::STG_IREF:  return txcal_pkg::SEL_IREF;
			txcal_pkg::STG_QREF:  return txcal_pkg::SEL_QREF;
			txcal_pkg::STG_ILO:   return txcal_pkg::SEL_IERR_LO;
			txcal_pkg::STG_QLO:   return txcal_pkg::SEL_QERR_LO;
			txcal_pkg::STG_RAISE: return txcal_pkg::SEL_QERR_HI;
			txcal_pkg::STG_QHI:   return txcal_pkg::SEL_QERR_HI;
			txcal_pkg::STG_IHI:   return txcal_pkg::SEL_IERR_HI;
			default:              return txcal_pkg::SEL_RESTORE;
		endcase
	endfunction : select_word

	assign nxt_stage = next_stage(st_reg.stage, st_reg.cfg, st_reg.iter);

	// ==========================================================
	// Next state
	always_comb begin
		st_next            = st_reg;
		st_next.ser_go     = 1'b0;
		st_next.conv_go    = 1'b0;
		st_next.conv_clear = 1'b0;
		start_req          = 1'b0;
		done_set           = 1'b0;
		rd_clear           = 1'b0;

		// Host writes
		if (reg_wr_en) begin
			if (reg_addr == txcal_pkg::ADDR_IQ_CTRL_I) begin
				st_next.lohi_i = reg_wdata;
			end else if (reg_addr == txcal_pkg::ADDR_IQ_CTRL_Q) begin
				st_next.lohi_q = reg_wdata;
			end else if (reg_addr == txcal_pkg::ADDR_CAL_CONFIG) begin
				st_next.cfg = reg_wdata;
			end else if (reg_addr == txcal_pkg::ADDR_CAL_TIMING) begin
				st_next.timing = reg_wdata;
			end else if (reg_addr == txcal_pkg::ADDR_MODEM_MODE) begin
				if (wr_mode == txcal_pkg::MODE_IDLE) begin
					st_next.tx_en = 1'b0;
				end else if (st_reg.phase == txcal_pkg::PH_IDLE) begin
					if (wr_mode == txcal_pkg::MODE_TX) begin
						st_next.tx_en = 1'b1;
					end else begin
						start_req        = 1'b1;
						st_next.tx_after = (wr_mode == txcal_pkg::MODE_TX_CAL);
						st_next.tx_en    = 1'b0;
					end
				end
			end
		end

		// Host reads, answered from a register next cycle
		if (reg_rd_en) begin
			if (reg_addr == txcal_pkg::ADDR_CAL_OFFSET_I) begin
				st_next.rdata = {{6{st_reg.corr_i[9]}}, st_reg.corr_i};
			end else if (reg_addr == txcal_pkg::ADDR_CAL_OFFSET_Q) begin
				st_next.rdata = {{6{st_reg.corr_q[9]}}, st_reg.corr_q};
			end else if (reg_addr == txcal_pkg::ADDR_IRQ_STATUS) begin
				st_next.rdata                             = 16'h0000;
				st_next.rdata[txcal_pkg::IRQ_TX_DONE_BIT] = st_reg.tx_done;
				rd_clear                                  = 1'b1;
			end else begin
				st_next.rdata = 16'h0000;
			end
		end

		// Sequencer
		case (st_reg.phase)
			txcal_pkg::PH_IDLE: begin
				if (start_req) begin
					st_next.stage      = txcal_pkg::STG_SETUP;
					st_next.phase      = txcal_pkg::PH_ADVANCE;
					st_next.iter       = 4'h0;
					st_next.conv_clear = 1'b1;
				end
			end
			txcal_pkg::PH_ADVANCE: begin
				st_next.stage       = nxt_stage;
				st_next.ser_word    = select_word(nxt_stage);
				st_next.ser_go      = 1'b1;
				st_next.phase       = txcal_pkg::PH_WAITSER;
				st_next.loop_settle = (nxt_stage == txcal_pkg::STG_ILO && st_reg.stage == txcal_pkg::STG_QLO)
					|| (nxt_stage == txcal_pkg::STG_QHI && st_reg.stage == txcal_pkg::STG_IHI);
				if (st_next.loop_settle) begin
					st_next.iter = st_reg.iter + 4'h1;
				end else if (st_reg.stage == txcal_pkg::STG_QLO || st_reg.stage == txcal_pkg::STG_IHI) begin
					st_next.iter = 4'h0;
				end
			end
			txcal_pkg::PH_WAITSER: begin
				if (ser_done) begin
					st_next.phase      = txcal_pkg::PH_SETTLE;
					st_next.tick_cnt   = 5'h00;
					st_next.settle_cnt = st_reg.loop_settle ? st_reg.timing[txcal_pkg::TIM_ITER_LSB +: 8]
						: st_reg.timing[txcal_pkg::TIM_SEL_LSB +: 8];
				end
			end
			txcal_pkg::PH_SETTLE: begin
				if (st_reg.settle_cnt != 8'h00) begin
					if (st_reg.tick_cnt == 5'(txcal_pkg::TICK_CYCLES - 1)) begin
						st_next.tick_cnt   = 5'h00;
						st_next.settle_cnt = st_reg.settle_cnt - 8'h01;
					end else begin
						st_next.tick_cnt = st_reg.tick_cnt + 5'h01;
					end
				end else if (st_reg.stage == txcal_pkg::STG_RAISE) begin
					st_next.corr_i = add_offset(st_reg.corr_i, st_reg.lohi_i);
					st_next.corr_q = add_offset(st_reg.corr_q, st_reg.lohi_q);
					st_next.phase  = txcal_pkg::PH_ADVANCE;
				end else if (st_reg.stage == txcal_pkg::STG_TIDY) begin
					st_next.phase = txcal_pkg::PH_IDLE;
					done_set      = 1'b1;
					st_next.tx_en = st_reg.tx_after;
				end else begin
					st_next.conv_go = 1'b1;
					st_next.phase   = txcal_pkg::PH_WAITCONV;
				end
			end
			txcal_pkg::PH_WAITCONV: begin
				if (conv_valid) begin
					st_next.phase = txcal_pkg::PH_ADVANCE;
					case (st_reg.stage)
						txcal_pkg::STG_IREF: st_next.ref_i = conv_result;
						txcal_pkg::STG_QREF: st_next.ref_q = conv_result;
						txcal_pkg::STG_ILO, txcal_pkg::STG_IHI: begin
							st_next.corr_i = correct(st_reg.corr_i, conv_result, st_reg.ref_i,
								st_reg.cfg[txcal_pkg::CFG_GAIN_LSB +: 4]);
						end
						txcal_pkg::STG_QLO, txcal_pkg::STG_QHI: begin
							st_next.corr_q = correct(st_reg.corr_q, conv_result, st_reg.ref_q,
								st_reg.cfg[txcal_pkg::CFG_GAIN_LSB +: 4]);
						end
						default: st_next.phase = txcal_pkg::PH_ADVANCE;
					endcase
				end
			end
			default: st_next.phase = txcal_pkg::PH_IDLE;
		endcase

		// Event set wins over a status read in the same cycle
		st_next.tx_done = (st_reg.tx_done & ~rd_clear) | done_set;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= '{stage: txcal_pkg::STG_SETUP, phase: txcal_pkg::PH_IDLE,
				lohi_i: txcal_pkg::IQ_CTRL_RESET, lohi_q: txcal_pkg::IQ_CTRL_RESET,
				cfg: txcal_pkg::CAL_CONFIG_RESET, timing: txcal_pkg::CAL_TIMING_RESET,
				ref_i: 10'h000, ref_q: 10'h000, corr_i: 10'h000, corr_q: 10'h000, iter: 4'h0,
				loop_settle: 1'b0, settle_cnt: 8'h00, tick_cnt: 5'h00, tx_after: 1'b0, tx_en: 1'b0,
				tx_done: 1'b0, rdata: 16'h0000, ser_word: 16'h0000, ser_go: 1'b0, conv_go: 1'b0,
				conv_clear: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Serial master and converter control
	passthru_serial u_serial (
		.clk                 (clk),
		.rst_n               (rst_n),
		.start               (st_reg.ser_go),
		.word                (st_reg.ser_word),
		.busy                (ser_busy),
		.done                (ser_done),
		.spi_sclk            (spi_sclk),
		.spi_mosi            (spi_mosi),
		.passthru_select_1_n (passthru_select_1_n)
	);

	aux_conv_ctrl u_conv (
		.clk          (clk),
		.rst_n        (rst_n),
		.clear        (st_reg.conv_clear),
		.request      (st_reg.conv_go),
		.adc_done     (adc_done),
		.adc_data     (adc_data),
		.adc_start    (adc_start),
		.adc_channel  (adc_channel),
		.result       (conv_result),
		.result_valid (conv_valid)
	);

	// ==========================================================
	// Outputs
	assign reg_rdata = st_reg.rdata;
	assign i_dc_out  = st_reg.corr_i;
	assign q_dc_out  = st_reg.corr_q;
	assign tx_enable = st_reg.tx_en;
	assign cal_busy  = (st_reg.phase != txcal_pkg::PH_IDLE);

	// ==========================================================
	// Checks
	a_no_tx_cal: assert property (@(posedge clk) disable iff (!rst_n)
		cal_busy |-> !tx_enable)
		else $error("transmit enabled during calibration");
	a_corr_retained: assert property (@(posedge clk) disable iff (!rst_n)
		!cal_busy && $past(!cal_busy) |-> $stable(i_dc_out) && $stable(q_dc_out))
		else $error("correction changed outside calibration");
	a_done_flag: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(cal_busy) |-> st_reg.tx_done && st_reg.stage == txcal_pkg::STG_TIDY)
		else $error("done flag not set at completion");
	a_first_select: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg.ser_go && st_reg.stage == txcal_pkg::STG_IREF |-> st_reg.ser_word == txcal_pkg::SEL_IREF
		&& $past(st_reg.stage) == txcal_pkg::STG_SETUP)
		else $error("setup did not select I reference");
	a_settle_after: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg.phase == txcal_pkg::PH_SETTLE && $past(st_reg.phase) == txcal_pkg::PH_WAITSER
		|-> $past(ser_done) && !ser_busy)
		else $error("settling began before frame end");
	a_conv_waited: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg.phase == txcal_pkg::PH_ADVANCE && $past(st_reg.phase) == txcal_pkg::PH_WAITCONV |-> $past(conv_valid))
		else $error("advanced without conversion result");
	a_high_order: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(st_reg.stage) && st_reg.stage == txcal_pkg::STG_QHI
		|-> $past(st_reg.stage) == txcal_pkg::STG_RAISE || $past(st_reg.stage) == txcal_pkg::STG_IHI)
		else $error("high gain stage without gain raise");
	a_tidy_restore: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(st_reg.stage) && st_reg.stage == txcal_pkg::STG_TIDY |-> st_reg.ser_word == txcal_pkg::SEL_RESTORE)
		else $error("tidy-up did not restore transmitter");
	a_low_first: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(st_reg.stage) && st_reg.stage == txcal_pkg::STG_ILO
		|-> $past(st_reg.stage) == txcal_pkg::STG_QREF || $past(st_reg.stage) == txcal_pkg::STG_QLO)
		else $error("low gain stage out of order");
endmodule : tx_dc_offset_calibration_sequencer
`default_nettype wire

// [pkg/txcal_pkg.sv]
// Constants, register map and types of the transmit dc offset calibration sequencer
`default_nettype none
package txcal_pkg;
	// ==========================================================
	// Clock, tick and serial timing
	localparam int CLK_PERIOD_NS    = 40;
	localparam int CLK_MHZ          = 25;
	localparam int TICK_US          = 1;
	localparam int TICK_CYCLES      = CLK_MHZ * TICK_US;
	localparam int SCLK_HALF_NS     = 160;
	localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SER_BITS         = 16;
	localparam int ADC_W            = 10;
	localparam int DC_W             = 10;
	localparam int GAIN_FRAC        = 4;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_IQ_CTRL_I    = 8'h5D;
	localparam logic [7:0] ADDR_IQ_CTRL_Q    = 8'h5E;
	localparam logic [7:0] ADDR_MODEM_MODE   = 8'h6B;
	localparam logic [7:0] ADDR_CAL_OFFSET_I = 8'h75;
	localparam logic [7:0] ADDR_CAL_OFFSET_Q = 8'h76;
	localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h7E;
	localparam logic [7:0] ADDR_CAL_TIMING   = 8'h90;
	localparam logic [7:0] ADDR_CAL_CONFIG   = 8'h91;
	// ==========================================================
	// Field positions, codes and reset values
	localparam int MODE_LSB        = 0;
	localparam int CFG_GAIN_LSB    = 0;
	localparam int CFG_ITER_LSB    = 4;
	localparam int CFG_LOW_BIT     = 8;
	localparam int CFG_RAISE_BIT   = 9;
	localparam int CFG_HIGH_BIT    = 10;
	localparam int TIM_SEL_LSB     = 0;
	localparam int TIM_ITER_LSB    = 8;
	localparam int IRQ_TX_DONE_BIT = 0;
	localparam logic [1:0]  MODE_IDLE        = 2'h0;
	localparam logic [1:0]  MODE_TX          = 2'h1;
	localparam logic [1:0]  MODE_TX_CAL      = 2'h2;
	localparam logic [1:0]  MODE_CAL         = 2'h3;
	localparam logic [15:0] CAL_CONFIG_RESET = 16'h0748;
	localparam logic [15:0] CAL_TIMING_RESET = 16'h6432;
	localparam logic [15:0] IQ_CTRL_RESET    = 16'h0000;
	localparam logic [1:0]  ADC_CHANNEL      = 2'h2;
	localparam logic signed [15:0] CORR_MAX  = 16'sh01FF;
	localparam logic signed [15:0] CORR_MIN  = 16'shFE00;
	// Command words to the loop transmitter
	localparam logic [15:0] SEL_IREF    = 16'h0101;
	localparam logic [15:0] SEL_QREF    = 16'h0102;
	localparam logic [15:0] SEL_IERR_LO = 16'h0103;
	localparam logic [15:0] SEL_QERR_LO = 16'h0104;
	localparam logic [15:0] SEL_IERR_HI = 16'h0183;
	localparam logic [15:0] SEL_QERR_HI = 16'h0184;
	localparam logic [15:0] SEL_RESTORE = 16'h0100;
	// ==========================================================
	// Types
	typedef enum logic [3:0] {STG_SETUP, STG_IREF, STG_QREF, STG_ILO, STG_QLO, STG_RAISE,
		STG_QHI, STG_IHI, STG_TIDY} stage_t;
	typedef enum logic [2:0] {PH_IDLE, PH_ADVANCE, PH_WAITSER, PH_SETTLE, PH_WAITCONV} phase_t;
endpackage : txcal_pkg
`default_nettype wire

// [src/passthru_serial.sv]
// Pass-through serial master: one 16-bit command frame per start
`timescale 1ns/1ps
`default_nettype none
module passthru_serial (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic [15:0] word,
	output logic             busy,
	output logic             done,
	output logic             spi_sclk,
	output logic             spi_mosi,
	output logic             passthru_select_1_n
);
	typedef struct packed {
		logic        active;
		logic [5:0]  half;
		logic [2:0]  div;
		logic [15:0] shreg;
		logic        sclk;
		logic        cs_n;
		logic        done;
	} ser_t;
	ser_t st_reg, st_next;

	localparam int SCLK_HALF_CYCLES = txcal_pkg::SCLK_HALF_CYCLES;

	always_comb begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		if (!st_reg.active) begin
			if (start) begin
				st_next.active = 1'b1;
				st_next.cs_n   = 1'b0;
				st_next.shreg  = word;
				st_next.half   = 6'h00;
				st_next.div    = 3'h0;
			end
		end else if (st_reg.div == 3'(SCLK_HALF_CYCLES - 1)) begin
			st_next.div  = 3'h0;
			st_next.half = st_reg.half + 6'h01;
			st_next.sclk = ~st_reg.half[0];
			if (st_reg.half[0]) begin
				st_next.shreg = {st_reg.shreg[14:0], 1'b0};
			end
			if (st_reg.half == 6'(2 * txcal_pkg::SER_BITS - 1)) begin
				st_next.active = 1'b0;
				st_next.cs_n   = 1'b1;
				st_next.done   = 1'b1;
			end
		end else begin
			st_next.div = st_reg.div + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= '{active: 1'b0, half: 6'h00, div: 3'h0, shreg: 16'h0000, sclk: 1'b0, cs_n: 1'b1, done: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy                = st_reg.active;
	assign done                = st_reg.done;
	assign spi_sclk            = st_reg.sclk;
	assign spi_mosi            = st_reg.shreg[15];
	assign passthru_select_1_n = st_reg.cs_n;

	a_frame_select: assert property (@(posedge clk) disable iff (!rst_n)
		start && !busy |=> (!passthru_select_1_n throughout (1'b1 ##127 1'b1)) ##1 done)
		else $error("select not held low through frame");
	a_done_release: assert property (@(posedge clk) disable iff (!rst_n)
		done |-> passthru_select_1_n && $past(!passthru_select_1_n))
		else $error("done without frame end");
endmodule : passthru_serial
`default_nettype wire

// [src/aux_conv_ctrl.sv]
// Auxiliary converter channel 2 request and result capture
`timescale 1ns/1ps
`default_nettype none
module aux_conv_ctrl (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clear,
	input  wire logic       request,
	input  wire logic       adc_done,
	input  wire logic [9:0] adc_data,
	output logic            adc_start,
	output logic [1:0]      adc_channel,
	output logic [9:0]      result,
	output logic            result_valid
);
	typedef struct packed {
		logic       waiting;
		logic       start;
		logic [9:0] result;
		logic       valid;
	} conv_t;
	conv_t st_reg, st_next;

	always_comb begin
		st_next       = st_reg;
		st_next.start = 1'b0;
		st_next.valid = 1'b0;
		if (clear) begin
			st_next.waiting = 1'b0;
			st_next.result  = 10'h000;
		end else if (!st_reg.waiting && request) begin
			st_next.waiting = 1'b1;
			st_next.start   = 1'b1;
		end else if (st_reg.waiting && adc_done && !st_reg.start) begin
			st_next.waiting = 1'b0;
			st_next.result  = adc_data;
			st_next.valid   = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= '{waiting: 1'b0, start: 1'b0, result: 10'h000, valid: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign adc_start    = st_reg.start;
	assign adc_channel  = txcal_pkg::ADC_CHANNEL;
	assign result       = st_reg.result;
	assign result_valid = st_reg.valid;

	a_channel_two: assert property (@(posedge clk) disable iff (!rst_n)
		adc_start |-> adc_channel == 2'h2)
		else $error("conversion not on channel 2");
	a_valid_cause: assert property (@(posedge clk) disable iff (!rst_n)
		result_valid |-> $past(adc_done) && result == $past(adc_data))
		else $error("result without conversion done");
endmodule : aux_conv_ctrl
`default_nettype wire

// [bench/loop_tx_model.sv]
// Loop transmitter and aux converter model
`timescale 1ns/1ps
`default_nettype none
module loop_tx_model (
	input  wire logic       clk,
	input  wire logic       spi_sclk,
	input  wire logic       spi_mosi,
	input  wire logic       passthru_select_1_n,
	input  wire logic       adc_start,
	input  wire logic [9:0] i_dc_out,
	input  wire logic [9:0] q_dc_out,
	input  wire logic       slow,
	output logic            adc_done = 1'b0,
	output logic [9:0]      adc_data = 10'h000,
	output logic [15:0]     last_word = 16'h0000,
	output logic [4:0]      last_len = 5'h00
);
	logic [15:0] sh  = 16'h0000;
	logic [4:0]  cnt = 5'h00;
	int          wt  = 0;
	int          dc;
	int          meas;
	// ==========================================================
	// Frame capture on the serial clock
	always @(posedge spi_sclk or posedge passthru_select_1_n) begin
		if (passthru_select_1_n) begin
			last_word <= sh;
			last_len  <= cnt;
			cnt       <= 5'h00;
		end else begin
			sh  <= {sh[14:0], spi_mosi};
			cnt <= cnt + 5'h01;
		end
	end
	// ==========================================================
	// Measurement output: references 512, errors scale with gain
	always_comb begin
		dc   = (last_word[2:0] == 3'h3) ? int'($signed(i_dc_out)) : int'($signed(q_dc_out));
		meas = 512 + ((last_word[2:0] > 3'h2) ? (last_word[7] ? 4 : 1) * (dc + 16) : 0);
	end
	// ==========================================================
	// Converter answer, prompt or slow
	always @(posedge clk) begin
		adc_done <= !adc_start && wt == 1;
		if (adc_done)
			adc_data <= ~adc_data;
		else if (!adc_start && wt == 1)
			adc_data <= meas[9:0];
		if (adc_start)
			wt <= slow ? 20 : 3;
		else if (wt != 0)
			wt <= wt - 1;
	end
endmodule : loop_tx_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench of the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct {logic [15:0] cfg; logic [1:0] md; logic [15:0] oi, oq; logic sl; logic [15:0] ei, eq; logic tx;} row_t;
	logic        clk = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0, slow = 0, adc_done, adc_start, sclk, mosi, sel_n;
	logic        tx_enable, cal_busy;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, d, last_word;
	logic [9:0]  adc_data, i_dc, q_dc;
	logic [1:0]  adc_channel;
	logic [4:0]  last_len;
	int          bad_count = 0, checked = 0;
	row_t        rows [4];
	tx_dc_offset_calibration_sequencer dut_u (.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_start(adc_start),
		.adc_channel(adc_channel), .adc_done(adc_done), .adc_data(adc_data), .spi_sclk(sclk), .spi_mosi(mosi),
		.passthru_select_1_n(sel_n), .i_dc_out(i_dc), .q_dc_out(q_dc), .tx_enable(tx_enable), .cal_busy(cal_busy));
	loop_tx_model far_u (.clk(clk), .spi_sclk(sclk), .spi_mosi(mosi), .passthru_select_1_n(sel_n),
		.adc_start(adc_start), .i_dc_out(i_dc), .q_dc_out(q_dc), .slow(slow), .adc_done(adc_done),
		.adc_data(adc_data), .last_word(last_word), .last_len(last_len));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk) {reg_wr_en, reg_addr, reg_wdata} <= {1'b1, a, v};
		@(posedge clk) reg_wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk) {reg_rd_en, reg_addr} <= {1'b1, a};
		@(posedge clk) reg_rd_en <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic stop_test;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	initial begin
		#3000000 bad_count++;
		stop_test();
	end
	initial begin
		rows[0] = '{16'h011F, 2'h3, 16'h0000, 16'h0000, 1'b0, 16'hFFF1, 16'hFFF1, 1'b0};
		rows[1] = '{16'h021F, 2'h2, 16'h0005, 16'h03FD, 1'b1, 16'hFFF6, 16'hFFEE, 1'b1};
		rows[2] = '{16'h0414, 2'h3, 16'h0005, 16'h03FD, 1'b0, 16'hFFF0, 16'hFFF0, 1'b0};
		rows[3] = '{16'h0728, 2'h3, 16'h0005, 16'h03FD, 1'b0, 16'hFFF5, 16'hFFED, 1'b0};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		wr(txcal_pkg::ADDR_CAL_TIMING, 16'h0101);
		for (int n = 0; n < 4; n++) begin
			wr(txcal_pkg::ADDR_MODEM_MODE, 16'h0000);
			wr(txcal_pkg::ADDR_IQ_CTRL_I, rows[n].oi);
			wr(txcal_pkg::ADDR_IQ_CTRL_Q, rows[n].oq);
			wr(txcal_pkg::ADDR_CAL_CONFIG, rows[n].cfg);
			slow <= rows[n].sl;
			wr(txcal_pkg::ADDR_MODEM_MODE, {14'h0000, rows[n].md});
			for (int i = 0; i < 20 && cal_busy !== 1'b1; i++) @(posedge clk);
			for (int i = 0; i < 20000 && cal_busy !== 1'b0; i++) @(posedge clk);
			chk({15'h0000, cal_busy}, 16'h0000);
			rd(txcal_pkg::ADDR_CAL_OFFSET_I);
			chk(d, rows[n].ei);
			rd(txcal_pkg::ADDR_CAL_OFFSET_Q);
			chk(d, rows[n].eq);
			chk({{6{i_dc[9]}}, i_dc}, rows[n].ei);
			chk({{6{q_dc[9]}}, q_dc}, rows[n].eq);
			chk({15'h0000, tx_enable}, {15'h0000, rows[n].tx});
			rd(txcal_pkg::ADDR_IRQ_STATUS);
			chk(d, 16'h0001);
			rd(txcal_pkg::ADDR_IRQ_STATUS);
			chk(d, 16'h0000);
			chk(last_word, txcal_pkg::SEL_RESTORE);
			chk({11'h000, last_len}, 16'h0010);
			$display("row %0d done", n);
		end
		wr(txcal_pkg::ADDR_CAL_OFFSET_I, 16'h1234);
		rd(txcal_pkg::ADDR_CAL_OFFSET_I);
		chk(d, 16'hFFF5);
		rd(8'hFF);
		chk(d, 16'h0000);
		wr(txcal_pkg::ADDR_MODEM_MODE, 16'h0001);
		#1 chk({15'h0000, tx_enable}, 16'h0001);
		$display("access test done");
		wr(txcal_pkg::ADDR_MODEM_MODE, 16'h0003);
		repeat (300) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({13'h0000, cal_busy, sel_n, tx_enable}, 16'h0002);
		chk({6'h00, i_dc}, 16'h0000);
		chk({14'h0000, adc_channel}, 16'h0002);
		@(posedge clk) rst_n <= 1'b1;
		rd(txcal_pkg::ADDR_CAL_OFFSET_I);
		chk(d, 16'h0000);
		$display("reset test done");
		stop_test();
	end
endmodule : testbench
`default_nettype wire
